//--- inc/cfr_consts.svh
// Named constants for the front-end control register block.
// Assumes inclusion by bare name from the package and the design files.
// Notes on behaviour
// - The serial configuration port and all registers keep working in every mode, stand-by included.
// - Mode bit 0 at value 0 means active operation and at value 1 means stand-by for all but the port and registers.
// - Polarity bit 0 serves the dummy clamp, bit 1 the black clamp, bit 2 both sample pulses; 0 is active low, 1 active high.
// - Registers hold no useful value until written over the serial port or until reset loads the defaults.
// - Reset loads mode 0, gain code 0010000000, clamp level code 1000 and polarity 000.
// - A ten-bit gain code selects the amplifier gain.
// - A four-bit code selects the optical-black clamp target, with the default standing for 32 LSB.
// - Sampling runs from the two sample pulses and from strobes derived from them; conversion runs from the conversion clock.
// - Each converted word is presented in step with the conversion clock input.
// - The far side asserts the black clamp pulse over optical-black pixels, and the clamp loop is enabled meanwhile.
// - The far side asserts the dummy clamp pulse over dummy pixels, and input clamping is enabled meanwhile.
// - In stand-by the conversion clock, both sample pulses and both clamp pulses are forced high inside.
`ifndef CFR_CONSTS_SVH
`define CFR_CONSTS_SVH

// Serial frame: 4-bit register address then 12 data bits, MSB first
`define CFR_FRAME_BITS 5'h10
`define CFR_ADDR_MSB 15
`define CFR_ADDR_LSB 12
`define CFR_ADDR_MODE 4'h0
`define CFR_ADDR_GAIN 4'h1
`define CFR_ADDR_CLAMP 4'h2
`define CFR_ADDR_POL 4'h3

// Reset values
`define CFR_MODE_RST 3'h0
`define CFR_GAIN_RST 10'h080
`define CFR_CLAMP_RST 4'h8
`define CFR_POL_RST 3'h0

// Field positions
`define CFR_STANDBY_BIT 0
`define CFR_POL_DUMMY_BIT 0
`define CFR_POL_BLACK_BIT 1
`define CFR_POL_SAMPLE_BIT 2

// Synchroniser width: three serial pins plus five pulse pins
`define CFR_SYNC_W 8
`define CFR_PULSE_N 5

`endif

//--- inc/cfr_pkg.sv
// Types shared by the front-end control register block.
// Assumes cfr_consts.svh is reachable on the include path.
`include "cfr_consts.svh"

package cfr_pkg;

  // Timing pulses, one bit each, in a fixed order
  typedef struct packed {
    logic convClk;
    logic refSample;
    logic vidSample;
    logic blackClamp;
    logic dummyClamp;
  } cfr_pulse_type;

  // Configuration registers as one bundle
  typedef struct packed {
    logic [2:0] operatingMode;
    logic [9:0] amplifierGain;
    logic [3:0] blackClampLevel;
    logic [2:0] pulsePolarity;
  } cfr_config_type;

  // Serial receiver states
  typedef enum logic [2:0] {
    CFR_IDLE = 3'b001,
    CFR_SHIFT = 3'b010,
    CFR_COMMIT = 3'b100
  } cfr_rx_state_type;

endpackage

//--- rtl/cfr_frontend_ctrl.sv
// Control registers and timing-pulse conditioning for a CCD front end.
// Assumes serial and pulse pins are asynchronous to clk, and the converter
// word comes from logic on clk. rst is the strobed reset pin.
`timescale 1ns/1ns
`default_nettype none

`include "cfr_consts.svh"

module cfr_frontend_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic serialLoadN,
  input wire logic conversionClock,
  input wire logic referenceSamplePulse,
  input wire logic videoSamplePulse,
  input wire logic blackClampPulse,
  input wire logic dummyClampPulse,
  input wire logic [11:0] converterWord,
  output var cfr_pkg::cfr_pulse_type condPulses,
  output logic standbySelect,
  output logic [9:0] amplifierGain,
  output logic [3:0] blackClampLevel,
  output logic clampLoopEnable,
  output logic inputClampEnable,
  output logic refSampleStrobe,
  output logic vidSampleStrobe,
  output logic [11:0] dataOut,
  output logic dataStrobe
);

  // Synchronised pins
  logic [`CFR_SYNC_W-1:0] pinsAsync;
  logic [`CFR_SYNC_W-1:0] pinsSync;
  logic sclkSync;
  logic sdataSync;
  logic loadNSync;
  cfr_pkg::cfr_pulse_type pulseSync;

  // Serial receiver state
  cfr_pkg::cfr_rx_state_type rxState_reg;
  cfr_pkg::cfr_rx_state_type rxState_next;
  logic sclkPrev_reg;
  logic sclkRise;
  logic [15:0] shift_reg;
  logic [4:0] bitCount_reg;

  // Configuration
  cfr_pkg::cfr_config_type config_reg;
  logic standbyNow;

  // Pulse conditioning
  logic [`CFR_PULSE_N-1:0] invertVec;
  logic [`CFR_PULSE_N-1:0] condVec;
  cfr_pkg::cfr_pulse_type condPrev_reg;

  // Every serial and pulse pin crosses two flip-flops before any logic reads it
  assign pinsAsync = {serialClk, serialData, serialLoadN, conversionClock,
    referenceSamplePulse, videoSamplePulse, blackClampPulse, dummyClampPulse};

  cfr_sync2 #(
    .WIDTH(`CFR_SYNC_W)
  ) pinSync (
    .clk(clk),
    .rst(rst),
    .asyncIn(pinsAsync),
    .syncOut(pinsSync)
  );

  // Split the synchronised vector back into named signals
  assign sclkSync = pinsSync[7];
  assign sdataSync = pinsSync[6];
  assign loadNSync = pinsSync[5];
  assign pulseSync = pinsSync[4:0];

  // Serial clock edge, taken from the second synchroniser stage only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sclkPrev_reg <= 1'b1; // Matches the synchroniser's reset level: no false edge
    else
      sclkPrev_reg <= sclkSync;
  end

  assign sclkRise = sclkSync & ~sclkPrev_reg;

  // Receiver sequencing; never gated by the mode bit
  always_comb
  begin
    rxState_next = rxState_reg;
    case (rxState_reg)
      cfr_pkg::CFR_IDLE:
      begin
        if (!loadNSync)
          rxState_next = cfr_pkg::CFR_SHIFT;
      end
      cfr_pkg::CFR_SHIFT:
      begin
        // A frame of the wrong length is dropped rather than half applied
        if (loadNSync)
        begin
          if (bitCount_reg == `CFR_FRAME_BITS)
            rxState_next = cfr_pkg::CFR_COMMIT;
          else
            rxState_next = cfr_pkg::CFR_IDLE;
        end
      end
      cfr_pkg::CFR_COMMIT:
      begin
        rxState_next = cfr_pkg::CFR_IDLE;
      end
      default:
      begin
        rxState_next = cfr_pkg::CFR_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rxState_reg <= cfr_pkg::CFR_IDLE;
    else
      rxState_reg <= rxState_next;
  end

  // Shift register and bit counter, MSB first on rising serial clock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      shift_reg <= 16'h0000;
      bitCount_reg <= 5'h00;
    end
    else if (rxState_reg == cfr_pkg::CFR_IDLE)
    begin
      bitCount_reg <= 5'h00;
    end
    else if (rxState_reg == cfr_pkg::CFR_SHIFT && !loadNSync && sclkRise)
    begin
      shift_reg <= {shift_reg[14:0], sdataSync};
      // Saturate one past a full frame so overlong frames are rejected
      if (bitCount_reg <= `CFR_FRAME_BITS)
        bitCount_reg <= bitCount_reg + 5'h01;
    end
  end

  // Register file; reset is the only way to defaults besides writing each
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      config_reg.operatingMode <= `CFR_MODE_RST;
      config_reg.amplifierGain <= `CFR_GAIN_RST;
      config_reg.blackClampLevel <= `CFR_CLAMP_RST;
      config_reg.pulsePolarity <= `CFR_POL_RST;
    end
    else if (rxState_reg == cfr_pkg::CFR_COMMIT)
    begin
      // Writes are accepted in stand-by as well
      case (shift_reg[`CFR_ADDR_MSB:`CFR_ADDR_LSB])
        `CFR_ADDR_MODE:
          config_reg.operatingMode <= shift_reg[2:0];
        `CFR_ADDR_GAIN:
          config_reg.amplifierGain <= shift_reg[9:0];
        `CFR_ADDR_CLAMP:
          config_reg.blackClampLevel <= shift_reg[3:0];
        `CFR_ADDR_POL:
          config_reg.pulsePolarity <= shift_reg[2:0];
        default:
          config_reg <= config_reg; // Unknown address: no effect
      endcase
    end
  end

  assign standbyNow = config_reg.operatingMode[`CFR_STANDBY_BIT];

  // Mirror the stored settings for the analog stages
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      standbySelect <= 1'b0;
      amplifierGain <= `CFR_GAIN_RST;
      blackClampLevel <= `CFR_CLAMP_RST;
    end
    else
    begin
      standbySelect <= standbyNow;
      amplifierGain <= config_reg.amplifierGain;
      blackClampLevel <= config_reg.blackClampLevel;
    end
  end

  // Per-pulse inversion; the conversion clock has no polarity bit
  assign invertVec = {1'b0,
    config_reg.pulsePolarity[`CFR_POL_SAMPLE_BIT],
    config_reg.pulsePolarity[`CFR_POL_SAMPLE_BIT],
    config_reg.pulsePolarity[`CFR_POL_BLACK_BIT],
    config_reg.pulsePolarity[`CFR_POL_DUMMY_BIT]};

  // One conditioner per pulse, all masked together in stand-by
  for (genvar i = 0; i < `CFR_PULSE_N; i++)
  begin : gen_cond
    cfr_pulse_cond pulseCond (
      .clk(clk),
      .rst(rst),
      .pinLevel(pulseSync[i]),
      .activeHigh(invertVec[i]),
      .maskOn(standbyNow),
      .condLevel(condVec[i])
    );
  end

  assign condPulses = condVec;

  // Previous conditioned levels for edge detection
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      condPrev_reg <= '1;
    else
      condPrev_reg <= condPulses;
  end

  // Clamp enables follow the active-low conditioned clamp pulses
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      clampLoopEnable <= 1'b0;
      inputClampEnable <= 1'b0;
    end
    else
    begin
      clampLoopEnable <= ~condPulses.blackClamp;
      inputClampEnable <= ~condPulses.dummyClamp;
    end
  end

  // Sample strobes mark the start of each active sample window
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      refSampleStrobe <= 1'b0;
      vidSampleStrobe <= 1'b0;
    end
    else
    begin
      refSampleStrobe <= condPrev_reg.refSample & ~condPulses.refSample;
      vidSampleStrobe <= condPrev_reg.vidSample & ~condPulses.vidSample;
    end
  end

  // Output word taken on the rising conversion clock; held high in
  // stand-by, so no words are issued there
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      dataOut <= 12'h000;
      dataStrobe <= 1'b0;
    end
    // The mask drives a low clock high on entry to stand-by; without the
    // gate that forced edge would issue a stray word
    else if (!standbySelect && (~condPrev_reg.convClk & condPulses.convClk))
    begin
      dataOut <= converterWord;
      dataStrobe <= 1'b1;
    end
    else
    begin
      dataStrobe <= 1'b0;
    end
  end

endmodule

`default_nettype wire

//--- rtl/cfr_pulse_cond.sv
// One timing-pulse conditioner: polarity correction and stand-by mask.
// Assumes a synchronised input; output is active low, idle high.
`timescale 1ns/1ns
`default_nettype none

module cfr_pulse_cond (
  input wire logic clk,
  input wire logic rst,
  input wire logic pinLevel,
  input wire logic activeHigh,
  input wire logic maskOn,
  output logic condLevel
);

  // Inverting active-high pulses first keeps all later logic on one level
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      condLevel <= 1'b1;
    else if (maskOn)
      condLevel <= 1'b1;
    else
      condLevel <= pinLevel ^ activeHigh;
  end

endmodule

`default_nettype wire

//--- rtl/cfr_sync2.sv
// Two-stage synchroniser for pin inputs.
// Assumes the inputs are asynchronous to clk; only stage two is read outside.
`timescale 1ns/1ns
`default_nettype none

module cfr_sync2 #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stageOneReg;

  // Reset to all ones, the idle level of every active-low pin
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      stageOneReg <= '1;
      syncOut <= '1;
    end
    else
    begin
      stageOneReg <= asyncIn;
      syncOut <= stageOneReg;
    end
  end

endmodule

`default_nettype wire

//--- sim/cfr_far_model.sv
// Timing generator and serial host standing at the far side of the block.
// Assumes tasks are called from the bench; all pins change at falling clk.
`timescale 1ns/1ns
`default_nettype none

module cfr_far_model (
  input wire logic clk,
  output logic serialClk,
  output logic serialData,
  output logic serialLoadN,
  output logic conversionClock,
  output logic referenceSamplePulse,
  output logic videoSamplePulse,
  output logic blackClampPulse,
  output logic dummyClampPulse,
  output logic [11:0] converterWord
);
  // Idle: frame closed, pulses at the default inactive level
  initial
  begin
    {serialClk, serialData, serialLoadN} = 3'h3;
    {conversionClock, referenceSamplePulse, videoSamplePulse} = 3'h7;
    {blackClampPulse, dummyClampPulse} = 2'h3;
    converterWord = 12'h000;
  end

  task automatic waitCycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Full frame MSB first; serial clock stands low outside frames
  task automatic sendFrame(input logic [3:0] addr, input logic [11:0] data);
    logic [15:0] frame;
    frame = {addr, data};
    serialLoadN = 1'b0;
    waitCycles(4);
    for (int i = 15; i >= 0; i--)
    begin
      serialData = frame[i];
      waitCycles(4);
      serialClk = 1'b1;
      waitCycles(4);
      serialClk = 1'b0;
    end
    serialLoadN = 1'b1;
    serialData = ~serialData; // Released line must not keep the last bit
    waitCycles(8);
  endtask

  // Pulses kept apart: dummy clamp has its own pin, no preblank overlap
  task automatic setPins(input logic [4:0] p);
    {conversionClock, referenceSamplePulse, videoSamplePulse} = p[4:2];
    {blackClampPulse, dummyClampPulse} = p[1:0];
    waitCycles(5);
  endtask

  // One conversion clock rise with the word held across capture
  task automatic convert(input logic [11:0] w);
    conversionClock = 1'b0;
    waitCycles(4);
    converterWord = w;
    conversionClock = 1'b1;
    waitCycles(5);
  endtask
endmodule

`default_nettype wire

//--- sim/cfr_frontend_ctrl_checker.sv
// Port-level assertions for the front-end control register block.
// Assumes binding to cfr_frontend_ctrl; sees only its ports.
`timescale 1ns/1ns
`default_nettype none

module cfr_frontend_ctrl_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic conversionClock,
  input wire logic [11:0] converterWord,
  input wire cfr_pkg::cfr_pulse_type condPulses,
  input wire logic standbySelect,
  input wire logic [9:0] amplifierGain,
  input wire logic [3:0] blackClampLevel,
  input wire logic clampLoopEnable,
  input wire logic inputClampEnable,
  input wire logic refSampleStrobe,
  input wire logic vidSampleStrobe,
  input wire logic [11:0] dataOut,
  input wire logic dataStrobe
);
  logic [2:0] sinceRst;

  // Pin pipeline holds stale reset values for the first edges, so count them
  always_ff @(posedge clk or posedge rst)
    if (rst)
      sinceRst <= 3'h0;
    else if (sinceRst != 3'h7)
      sinceRst <= sinceRst + 3'h1;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Start edges of the conditioned pulses outside stand-by transitions
  sequence s_conv_rise;
    !standbySelect && $rose(condPulses.convClk);
  endsequence
  sequence s_ref_start;
    !standbySelect && !$past(standbySelect) && $fell(condPulses.refSample);
  endsequence
  sequence s_vid_start;
    !standbySelect && !$past(standbySelect) && $fell(condPulses.vidSample);
  endsequence

  a_reset_defaults: assert property ($fell(rst) |-> !standbySelect &&
    amplifierGain == 10'h080 && blackClampLevel == 4'h8)
    else $error("register defaults wrong after reset");
  a_standby_mask: assert property (standbySelect |-> condPulses == 5'h1f)
    else $error("pulses not masked high in stand-by");
  a_standby_quiet: assert property (standbySelect && $past(standbySelect) |->
    !(clampLoopEnable || inputClampEnable || refSampleStrobe || vidSampleStrobe || dataStrobe))
    else $error("activity during stand-by");
  a_black_clamp: assert property (clampLoopEnable == !$past(condPulses.blackClamp))
    else $error("clamp loop enable does not follow black clamp");
  a_dummy_clamp: assert property (inputClampEnable == !$past(condPulses.dummyClamp))
    else $error("input clamp enable does not follow dummy clamp");
  a_conv_path: assert property (sinceRst >= 3'h4 && !standbySelect |->
    condPulses.convClk == $past(conversionClock, 3))
    else $error("conversion clock path latency wrong");
  a_data_capture: assert property (s_conv_rise |=>
    dataStrobe && dataOut == $past(converterWord))
    else $error("word not captured at conversion clock rise");
  a_strobe_cause: assert property (dataStrobe |->
    $past(condPulses.convClk) && !$past(condPulses.convClk, 2))
    else $error("data strobe without clock rise");
  a_ref_strobe: assert property (s_ref_start |=> refSampleStrobe)
    else $error("reference sample strobe missing");
  a_vid_strobe: assert property (s_vid_start |=> vidSampleStrobe)
    else $error("video sample strobe missing");
endmodule

bind cfr_frontend_ctrl cfr_frontend_ctrl_checker chk (.clk(clk), .rst(rst),
  .conversionClock(conversionClock), .converterWord(converterWord), .condPulses(condPulses),
  .standbySelect(standbySelect), .amplifierGain(amplifierGain),
  .blackClampLevel(blackClampLevel), .clampLoopEnable(clampLoopEnable),
  .inputClampEnable(inputClampEnable), .refSampleStrobe(refSampleStrobe),
  .vidSampleStrobe(vidSampleStrobe), .dataOut(dataOut), .dataStrobe(dataStrobe));

`default_nettype wire

//--- sim/test_ccd_frontend_control_regs.sv
// Self-checking bench for the front-end control register block.
// Assumes the far-side model drives every pin input of the design but clk and rst, which the bench drives itself.
`timescale 1ns/1ns
`default_nettype none

module test_ccd_frontend_control_regs;
  logic clk, rst, serialClk, serialData, serialLoadN, conversionClock;
  logic referenceSamplePulse, videoSamplePulse, blackClampPulse, dummyClampPulse;
  logic standbySelect, clampLoopEnable, inputClampEnable, refSampleStrobe, vidSampleStrobe;
  logic dataStrobe;
  logic [11:0] converterWord;
  logic [11:0] dataOut;
  logic [9:0] amplifierGain;
  logic [3:0] blackClampLevel;
  cfr_pkg::cfr_pulse_type condPulses;
  int bad_count, cmp_count, refCount, vidCount, datCount;
  logic [2:0] pols [3] = '{3'h0, 3'h5, 3'h2};

  cfr_far_model far (.clk(clk), .serialClk(serialClk), .serialData(serialData),
    .serialLoadN(serialLoadN), .conversionClock(conversionClock),
    .referenceSamplePulse(referenceSamplePulse), .videoSamplePulse(videoSamplePulse),
    .blackClampPulse(blackClampPulse), .dummyClampPulse(dummyClampPulse),
    .converterWord(converterWord));
  cfr_frontend_ctrl dut (.clk(clk), .rst(rst), .serialClk(serialClk), .serialData(serialData),
    .serialLoadN(serialLoadN), .conversionClock(conversionClock),
    .referenceSamplePulse(referenceSamplePulse), .videoSamplePulse(videoSamplePulse),
    .blackClampPulse(blackClampPulse), .dummyClampPulse(dummyClampPulse),
    .converterWord(converterWord), .condPulses(condPulses), .standbySelect(standbySelect),
    .amplifierGain(amplifierGain), .blackClampLevel(blackClampLevel),
    .clampLoopEnable(clampLoopEnable), .inputClampEnable(inputClampEnable),
    .refSampleStrobe(refSampleStrobe), .vidSampleStrobe(vidSampleStrobe),
    .dataOut(dataOut), .dataStrobe(dataStrobe));

  // 100 MHz clock
  always #5 clk = ~clk;

  // Strobe tally, cleared by the bench before each window
  always @(posedge clk)
  begin
    refCount = refCount + int'(refSampleStrobe);
    vidCount = vidCount + int'(vidSampleStrobe);
    datCount = datCount + int'(dataStrobe);
  end

  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic checkDefaults;
    check(amplifierGain, 12'h080);
    check(blackClampLevel, 12'h008);
    check(standbySelect, 12'h000);
  endtask

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Cuts a hung run short
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize();
  end

  // Main sequence
  initial
  begin
    logic [2:0] p;
    {clk, rst, bad_count, cmp_count, refCount, vidCount, datCount} = '0;
    rst = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    checkDefaults();
    check(condPulses, 12'h01f);
    far.sendFrame(4'h1, 12'h3ff);
    check(amplifierGain, 12'h3ff);
    far.sendFrame(4'h2, 12'h005);
    check(blackClampLevel, 12'h005);
    // Each polarity set: inactive, then active, then inactive again
    foreach (pols[i])
    begin
      p = pols[i];
      far.sendFrame(4'h3, {9'h000, p});
      far.setPins({1'b1, ~p[2], ~p[2], ~p[1], ~p[0]});
      {refCount, vidCount} = '0;
      far.setPins({1'b0, p[2], p[2], p[1], p[0]});
      check(condPulses, 12'h000);
      check({clampLoopEnable, inputClampEnable}, 12'h003);
      check({refCount[3:0], vidCount[3:0]}, 12'h011);
      far.setPins({1'b1, ~p[2], ~p[2], ~p[1], ~p[0]});
      check(condPulses, 12'h01f);
      check({clampLoopEnable, inputClampEnable}, 12'h000);
    end
    // One pulse at a time, so that each clamp and sample pin is seen apart from its neighbours
    for (int j = 0; j < 4; j++)
    begin
      {refCount, vidCount} = '0;
      far.setPins(5'h1d ^ (5'h01 << j));
      check(condPulses, 12'h01f ^ (12'h001 << j));
      check({clampLoopEnable, inputClampEnable}, {10'h000, j == 1, j == 0});
      check({refCount[3:0], vidCount[3:0]}, {4'h0, 3'h0, j == 3, 3'h0, j == 2});
      far.setPins(5'h1d);
    end
    {refCount, vidCount, datCount} = '0;
    far.convert(12'ha5c);
    check(dataOut, 12'ha5c);
    far.convert(12'h5a3);
    check(dataOut, 12'h5a3);
    check(datCount[3:0], 12'h002);
    // Stand-by masks every pulse but leaves the serial port working; the pins
    // stand low while it is entered, so the mask itself must make no word
    far.setPins(5'h00);
    {refCount, vidCount, datCount} = '0;
    far.sendFrame(4'h0, 12'h001);
    check(standbySelect, 12'h001);
    far.setPins(5'h00);
    check(condPulses, 12'h01f);
    check({clampLoopEnable, inputClampEnable}, 12'h000);
    far.setPins(5'h1f);
    far.setPins(5'h00);
    far.convert(12'h777);
    check(dataOut, 12'h5a3);
    check({refCount[3:0], vidCount[3:0], datCount[3:0]}, 12'h000);
    far.sendFrame(4'h1, 12'h123);
    check(amplifierGain, 12'h123);
    far.sendFrame(4'h0, 12'h000);
    check(standbySelect, 12'h000);
    // Strobing reset mid-run restores every default
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    checkDefaults();
    check(condPulses, 12'h01f);
    summarize();
  end
endmodule

`default_nettype wire
